// >>> shared/odb_pkg.sv
`default_nettype none
package odb_pkg;
    // sizes of the output stage
    localparam int N_OUT  = 12;
    localparam int N_INT  = 5;
    localparam int N_FRAC = 2;
    localparam int N_SRC  = N_INT + N_FRAC;
    localparam int W_DIV   = 6;
    localparam int W_MODE  = 4;
    localparam int W_SKEW  = 4;
    localparam int W_SLEW  = 2;
    localparam int W_RATIO = 8;

    // register byte addresses
    localparam logic [7:0] A_OUT_BASE  = 8'h00;
    localparam logic [7:0] A_INT_BASE  = 8'h30;
    localparam logic [7:0] A_FRAC_BASE = 8'h44;
    localparam logic [7:0] A_CTRL      = 8'h54;
    localparam logic [7:0] A_STAT      = 8'h58;

    // per-output word fields
    localparam int F_DIV  = 0;
    localparam int F_MODE = 8;
    localparam int F_SKEW = 12;
    localparam int F_STOP = 16;
    localparam int F_INV  = 17;
    localparam int F_SLEW = 18;
    localparam int F_STR  = 20;
    localparam logic [20:0] OUT_MASK = 21'h1FFF3F;
    // integer divider word fields
    localparam int F_RA   = 0;
    localparam int F_RB   = 8;
    localparam int F_ISEL = 16;
    // fractional bank word and control fields
    localparam int F_FR    = 0;
    localparam int F_SS    = 8;
    localparam int F_FSEL  = 0;
    localparam int F_FS_EN = 8;
    localparam int F_FS_ST = 8;

    // reset values and the lowest ratio a divider takes
    localparam logic [20:0]        R_OUT   = 21'h000000;
    localparam logic [W_RATIO-1:0] R_RATIO = 8'h08;
    localparam logic [W_RATIO-1:0] RATIO_MIN = 8'h01;

    // skew step timing
    localparam int SKEW_STEP_PS = 35;
    localparam int SKEW_MAX_PS  = 280;
    localparam logic [W_SKEW-1:0] SKEW_MAX = W_SKEW'(SKEW_MAX_PS / SKEW_STEP_PS);

    // driver format codes
    localparam logic [W_MODE-1:0] M_OFF     = 4'h0;
    localparam logic [W_MODE-1:0] M_SE_TRUE = 4'h1;
    localparam logic [W_MODE-1:0] M_SE_COMP = 4'h2;
    localparam logic [W_MODE-1:0] M_SE_DUAL = 4'h3;
    localparam logic [W_MODE-1:0] M_LVDS    = 4'h4;
    localparam logic [W_MODE-1:0] M_HCSL    = 4'h8;
    localparam logic [W_MODE-1:0] M_ECL     = 4'hC;

    typedef enum logic [2:0] {FMT_OFF, FMT_SE, FMT_LVDS, FMT_LVDS_FAST, FMT_HCSL, FMT_ECL} odb_fmt_t;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } odb_bus_t;

    // one output driver's pins and analog settings
    typedef struct packed {
        logic              p_lvl;
        logic              n_lvl;
        logic              p_oe_n;
        logic              n_oe_n;
        odb_fmt_t          fmt;
        logic [W_MODE-1:0] code;
        logic              low_supply;
        logic              term_int;
        logic              imp_42;
        logic [W_SKEW-1:0] delay;
        logic [W_SLEW-1:0] slew;
        logic              imp_25;
    } odb_drv_t;

    // source (group) feeding each output
    localparam int GRP_OF_OUT [N_OUT] = '{0, 1, 1, 2, 2, 2, 3, 3, 3, 4, 5, 5};

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] base, input int idx);
        return a == base + 8'(idx * 4);
    endfunction

    function automatic logic [W_RATIO-1:0] clamp_ratio(input logic [W_RATIO-1:0] r);
        return (r < RATIO_MIN) ? RATIO_MIN : r;
    endfunction

    function automatic odb_fmt_t dec_fmt(input logic [W_MODE-1:0] m);
        if (m == M_OFF) begin
            return FMT_OFF;
        end else if (m < M_LVDS) begin
            return FMT_SE;
        end else if (m < M_LVDS + 4'h2) begin
            return FMT_LVDS;
        end else if (m < M_HCSL) begin
            return FMT_LVDS_FAST;
        end else if (m < M_ECL) begin
            return FMT_HCSL;
        end else if (m == M_ECL) begin
            return FMT_ECL;
        end else begin
            return FMT_OFF;
        end
    endfunction
endpackage
`default_nettype wire

// >>> core/odb_int_div.sv
`default_nettype none
module odb_int_div (
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst_b,
    input  wire logic [odb_pkg::W_RATIO-1:0]   i_ratio_a,
    input  wire logic [odb_pkg::W_RATIO-1:0]   i_ratio_b,
    input  wire logic                          i_sel,
    output logic                               o_clk,
    output logic                               o_tick,
    output logic                               o_bank
);
    import odb_pkg::*;

    logic [W_RATIO-1:0] cnt;
    logic [W_RATIO-1:0] ratio;
    logic               edge_end;
    logic [W_RATIO-1:0] next_ratio;
    logic [W_RATIO-1:0] next_cnt;

    // bank choice only sampled at the period boundary
    assign edge_end   = (cnt <= 8'h01);
    assign next_ratio = edge_end ? clamp_ratio(i_sel ? i_ratio_b : i_ratio_a) : ratio;
    assign next_cnt   = edge_end ? next_ratio : cnt - 8'h01;

    // period counter, high for the upper half of each period
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            cnt    <= R_RATIO;
            ratio  <= R_RATIO;
            o_bank <= 1'b0;
            o_clk  <= 1'b0;
            o_tick <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            ratio  <= next_ratio;
            o_bank <= edge_end ? i_sel : o_bank;
            o_clk  <= (next_cnt > (next_ratio >> 1)) || (next_ratio == 8'h01);
            o_tick <= edge_end;
        end
    end
endmodule
`default_nettype wire

// >>> core/odb_out_div.sv
`default_nettype none
module odb_out_div (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_rst_b,
    input  wire logic                        i_tick,
    input  wire logic                        i_src_clk,
    input  wire logic [odb_pkg::W_DIV-1:0]   i_ratio,
    output logic                             o_clk,
    output logic                             o_live
);
    import odb_pkg::*;

    logic [W_DIV-1:0] cnt;
    logic [W_DIV-1:0] act;
    logic             edge_end;

    // new ratio taken only at the end of an output period
    assign edge_end = i_tick && (cnt <= 6'h01);

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            cnt    <= 6'h00;
            act    <= 6'h00;
            o_clk  <= 1'b0;
            o_live <= 1'b0;
        end else begin
            cnt    <= edge_end ? i_ratio : (i_tick ? cnt - 6'h01 : cnt);
            act    <= edge_end ? i_ratio : act;
            o_live <= edge_end ? (i_ratio != 6'h00) : o_live;
            // zero holds low, one passes the group clock, else half-period split
            o_clk  <= (act == 6'h00) ? 1'b0 : (act == 6'h01) ? i_src_clk : (cnt > (act >> 1));
        end
    end
endmodule
`default_nettype wire

// >>> core/odb_top.sv
// Overview of operation
// - twelve final dividers; zero disables output, 1..63 divides group clock
// - skew field is unsigned 35 ps steps, capped at 280 ps
// - stopped driver holds low-z low when bit clear, high-z when set
// - dual single-ended polarity bit inverts the complementary output when set
// - two-bit edge rate: fastest, slow, slower, slowest
// - impedance bit picks 50 ohm when clear, 25 ohm when set
// - format codes 0 off, 1 true only, 2 complement only, 3 both
// - codes 4..7 differential low swing, two supplies, fast variants
// - codes 8..11 host clock 50/42.5 ohm ext/int; 12 emitter-coupled
// - every integer and fractional divider holds primary and alternate banks
// - integer divider bank bit picks primary or alternate ratio, taken at the period end
// - fractional divider switches whole configuration on select change
// - spread enables act immediately even in the selected bank
// - any primary-bank output can switch to its alternate frequency
// - frequency select pin switches banks like the control bits
// - with select asserted, alternate values set affected output frequencies
// - bank switching is glitch-free with no runt pulses
// - spread enable zero disables modulation, one enables, writable anytime
//
// Decided for this implementation: the address map and the address-and-strobe port.
`default_nettype none
module odb_top (
    input  wire logic                                  i_sys_clk,
    input  wire logic                                  i_rst_b,
    input  wire odb_pkg::odb_bus_t                     i_bus,
    output logic [31:0]                                o_rdata,
    input  wire logic                                  i_frequency_select_pin,
    output odb_pkg::odb_drv_t [odb_pkg::N_OUT-1:0]     o_drv,
    output logic [odb_pkg::N_SRC-1:0]                  o_src_clk,
    output logic [odb_pkg::N_FRAC-1:0]                 o_spread_en
);
    import odb_pkg::*;

    // software-visible state
    logic [20:0]        out_cfg  [N_OUT];
    logic [16:0]        int_cfg  [N_INT];
    logic [8:0]         frac_cfg [N_FRAC][2];
    logic [N_FRAC-1:0]  frac_sel;
    logic               fs_en;

    // pin synchroniser
    logic               fs_meta;
    logic               fs_sync;

    // fractional working configuration
    logic [W_RATIO-1:0] frac_snap [N_FRAC];
    logic [N_FRAC-1:0]  frac_act_sel;

    // divider outputs
    logic [N_SRC-1:0]   src_clk;
    logic [N_SRC-1:0]   src_tick;
    logic [N_SRC-1:0]   src_bank;
    logic [N_OUT-1:0]   out_clk;
    logic [N_OUT-1:0]   out_live;

    // decode and selection wires
    logic [N_OUT-1:0]   hit_out;
    logic [N_INT-1:0]   hit_int;
    logic [2*N_FRAC-1:0] hit_frac;
    logic               hit_ctrl;
    logic               hit_stat;
    logic               fs_force;
    logic [N_INT-1:0]   int_sel_eff;
    logic [N_FRAC-1:0]  frac_sel_eff;
    logic [31:0]        next_rdata;
    odb_drv_t           next_drv [N_OUT];

    // register address decode
    assign hit_ctrl = (i_bus.addr == A_CTRL);
    assign hit_stat = (i_bus.addr == A_STAT);
    for (genvar i = 0; i < N_OUT; i++) begin : g_hit_out
        assign hit_out[i] = reg_hit(i_bus.addr, A_OUT_BASE, i);
    end
    for (genvar i = 0; i < N_INT; i++) begin : g_hit_int
        assign hit_int[i] = reg_hit(i_bus.addr, A_INT_BASE, i);
    end
    for (genvar i = 0; i < 2 * N_FRAC; i++) begin : g_hit_frac
        assign hit_frac[i] = reg_hit(i_bus.addr, A_FRAC_BASE, i);
    end

    // frequency select pin acts as a second source of every bank bit
    assign fs_force = fs_en & fs_sync;
    for (genvar i = 0; i < N_INT; i++) begin : g_isel
        assign int_sel_eff[i] = int_cfg[i][F_ISEL] | fs_force;
    end
    for (genvar f = 0; f < N_FRAC; f++) begin : g_fsel
        assign frac_sel_eff[f] = frac_sel[f] | fs_force;
    end

    // two-flop synchroniser for the select pin
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            fs_meta <= 1'b0;
            fs_sync <= 1'b0;
        end else begin
            fs_meta <= i_frequency_select_pin;
            fs_sync <= fs_meta;
        end
    end

    // per-output words
    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < N_OUT; i++) begin
            if (!i_rst_b) begin
                out_cfg[i] <= R_OUT;
            end else if (i_bus.wr && hit_out[i]) begin
                out_cfg[i] <= i_bus.wdata[20:0] & OUT_MASK;
            end
        end
    end

    // integer divider words: both banks and the select bit
    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < N_INT; i++) begin
            if (!i_rst_b) begin
                int_cfg[i] <= {1'b0, R_RATIO, R_RATIO};
            end else if (i_bus.wr && hit_int[i]) begin
                int_cfg[i] <= i_bus.wdata[16:0];
            end
        end
    end

    // fractional bank words, staged until selected
    always_ff @(posedge i_sys_clk) begin
        for (int f = 0; f < N_FRAC; f++) begin
            for (int b = 0; b < 2; b++) begin
                if (!i_rst_b) begin
                    frac_cfg[f][b] <= {1'b0, R_RATIO};
                end else if (i_bus.wr && hit_frac[2 * f + b]) begin
                    frac_cfg[f][b] <= i_bus.wdata[8:0];
                end
            end
        end
    end

    // control word: fractional selects and pin enable
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            frac_sel <= '0;
            fs_en    <= 1'b0;
        end else if (i_bus.wr && hit_ctrl) begin
            frac_sel <= i_bus.wdata[F_FSEL +: N_FRAC];
            fs_en    <= i_bus.wdata[F_FS_EN];
        end
    end

    // snapshot of the newly selected bank, taken only when select moves
    always_ff @(posedge i_sys_clk) begin
        for (int f = 0; f < N_FRAC; f++) begin
            if (!i_rst_b) begin
                frac_snap[f]    <= R_RATIO;
                frac_act_sel[f] <= 1'b0;
            end else if (frac_sel_eff[f] != frac_act_sel[f]) begin
                frac_snap[f]    <= frac_cfg[f][frac_sel_eff[f]][F_FR +: W_RATIO];
                frac_act_sel[f] <= frac_sel_eff[f];
            end
        end
    end

    // spread enable follows the live bank at once
    always_ff @(posedge i_sys_clk) begin
        for (int f = 0; f < N_FRAC; f++) begin
            if (!i_rst_b) begin
                o_spread_en[f] <= 1'b0;
            end else begin
                o_spread_en[f] <= frac_cfg[f][frac_sel_eff[f]][F_SS];
            end
        end
    end

    // integer dividers, bank latched at period end
    for (genvar i = 0; i < N_INT; i++) begin : g_int
        odb_int_div u_int (
            .i_sys_clk (i_sys_clk),
            .i_rst_b   (i_rst_b),
            .i_ratio_a (int_cfg[i][F_RA +: W_RATIO]),
            .i_ratio_b (int_cfg[i][F_RB +: W_RATIO]),
            .i_sel     (int_sel_eff[i]),
            .o_clk     (src_clk[i]),
            .o_tick    (src_tick[i]),
            .o_bank    (src_bank[i])
        );
    end

    // fractional dividers run from the snapshot ratio
    for (genvar f = 0; f < N_FRAC; f++) begin : g_frac
        odb_int_div u_frac (
            .i_sys_clk (i_sys_clk),
            .i_rst_b   (i_rst_b),
            .i_ratio_a (frac_snap[f]),
            .i_ratio_b (frac_snap[f]),
            .i_sel     (frac_act_sel[f]),
            .o_clk     (src_clk[N_INT + f]),
            .o_tick    (src_tick[N_INT + f]),
            .o_bank    (src_bank[N_INT + f])
        );
    end

    assign o_src_clk = src_clk;

    // final per-output dividers off their group clock
    for (genvar i = 0; i < N_OUT; i++) begin : g_out
        odb_out_div u_out (
            .i_sys_clk (i_sys_clk),
            .i_rst_b   (i_rst_b),
            .i_tick    (src_tick[GRP_OF_OUT[i]]),
            .i_src_clk (src_clk[GRP_OF_OUT[i]]),
            .i_ratio   (out_cfg[i][F_DIV +: W_DIV]),
            .o_clk     (out_clk[i]),
            .o_live    (out_live[i])
        );
    end

    // driver pin and setting derivation
    always_comb begin
        for (int i = 0; i < N_OUT; i++) begin
            logic [W_MODE-1:0] m;
            logic              c;
            logic              hold_hz;
            m = out_cfg[i][F_MODE +: W_MODE];
            c = out_clk[i];
            hold_hz = out_cfg[i][F_STOP];
            next_drv[i].code       = m;
            next_drv[i].fmt        = dec_fmt(m);
            next_drv[i].low_supply = (m >= M_LVDS) && (m < M_HCSL) && m[0];
            next_drv[i].term_int   = (m >= M_HCSL) && (m < M_ECL) && m[0];
            next_drv[i].imp_42     = (m >= M_HCSL) && (m < M_ECL) && m[1];
            next_drv[i].delay      = (out_cfg[i][F_SKEW +: W_SKEW] > SKEW_MAX) ?
                                     SKEW_MAX : out_cfg[i][F_SKEW +: W_SKEW];
            next_drv[i].slew       = out_cfg[i][F_SLEW +: W_SLEW];
            next_drv[i].imp_25     = out_cfg[i][F_STR];
            next_drv[i].p_lvl      = 1'b0;
            next_drv[i].n_lvl      = 1'b0;
            next_drv[i].p_oe_n     = 1'b1;
            next_drv[i].n_oe_n     = 1'b1;
            if (next_drv[i].fmt == FMT_OFF) begin
                next_drv[i].p_oe_n = 1'b1;
            end else if (!out_live[i]) begin
                // stopped: pins low at low-z, or released
                next_drv[i].p_oe_n = (m != M_SE_COMP) ? hold_hz : 1'b1;
                next_drv[i].n_oe_n = (m != M_SE_TRUE) ? hold_hz : 1'b1;
            end else if (m == M_SE_TRUE) begin
                next_drv[i].p_lvl  = c;
                next_drv[i].p_oe_n = 1'b0;
            end else if (m == M_SE_COMP) begin
                next_drv[i].n_lvl  = c;
                next_drv[i].n_oe_n = 1'b0;
            end else if (m == M_SE_DUAL) begin
                next_drv[i].p_lvl  = c;
                next_drv[i].n_lvl  = out_cfg[i][F_INV] ? ~c : c;
                next_drv[i].p_oe_n = 1'b0;
                next_drv[i].n_oe_n = 1'b0;
            end else begin
                // differential formats drive a true pair
                next_drv[i].p_lvl  = c;
                next_drv[i].n_lvl  = ~c;
                next_drv[i].p_oe_n = 1'b0;
                next_drv[i].n_oe_n = 1'b0;
            end
        end
    end

    // driver outputs from flops
    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < N_OUT; i++) begin
            if (!i_rst_b) begin
                o_drv[i] <= '{p_lvl: 1'b0, n_lvl: 1'b0, p_oe_n: 1'b1, n_oe_n: 1'b1, fmt: FMT_OFF,
                              default: '0};
            end else begin
                o_drv[i] <= next_drv[i];
            end
        end
    end

    // read selection
    always_comb begin
        next_rdata = 32'h00000000;
        for (int i = 0; i < N_OUT; i++) begin
            if (hit_out[i]) begin
                next_rdata = {11'h000, out_cfg[i]};
            end
        end
        for (int i = 0; i < N_INT; i++) begin
            if (hit_int[i]) begin
                next_rdata = {15'h0000, int_cfg[i]};
            end
        end
        for (int f = 0; f < N_FRAC; f++) begin
            for (int b = 0; b < 2; b++) begin
                if (hit_frac[2 * f + b]) begin
                    next_rdata = {23'h000000, frac_cfg[f][b]};
                end
            end
        end
        if (hit_ctrl) begin
            next_rdata = {23'h000000, fs_en, 6'h00, frac_sel};
        end else if (hit_stat) begin
            next_rdata = {23'h000000, fs_sync, 1'b0, src_bank};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= i_bus.rd ? next_rdata : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// >>> sim/odb_top_assertions.sv
`default_nettype none
module odb_top_checker (
    input wire logic                                   i_sys_clk,
    input wire logic                                   i_rst_b,
    input wire odb_pkg::odb_bus_t                      i_bus,
    input wire logic [31:0]                            o_rdata,
    input wire logic                                   i_frequency_select_pin,
    input wire odb_pkg::odb_drv_t [odb_pkg::N_OUT-1:0] o_drv,
    input wire logic [odb_pkg::N_SRC-1:0]              o_src_clk,
    input wire logic [odb_pkg::N_FRAC-1:0]             o_spread_en
);
    timeunit 1ns;
    timeprecision 1ps;
    import odb_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // register request shapes
    sequence s_wr(logic [7:0] a);
        i_bus.wr && i_bus.addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        i_bus.rd && i_bus.addr == a;
    endsequence
    property p_out_rb;
        s_wr(A_OUT_BASE) ##1 s_rd(A_OUT_BASE) |=> o_rdata == {11'h0, $past(i_bus.wdata[20:0], 2) & OUT_MASK};
    endproperty
    a_out_rb: assert property (p_out_rb) else $error("output word readback wrong");
    property p_int_rb;
        s_wr(A_INT_BASE) ##1 s_rd(A_INT_BASE) |=> o_rdata == {15'h0, $past(i_bus.wdata[16:0], 2)};
    endproperty
    a_int_rb: assert property (p_int_rb) else $error("integer bank word readback wrong");
    property p_ctrl_rb;
        s_wr(A_CTRL) ##1 s_rd(A_CTRL) |=> o_rdata ==
            {23'h0, $past(i_bus.wdata[8], 2), 6'h0, $past(i_bus.wdata[1:0], 2)};
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("bank select readback wrong");
    // every driver under watch
    for (genvar j = 0; j < N_OUT; j++) begin : g_drv
        odb_drv_t dj;
        assign dj = o_drv[j];
        property p_reserved;
            dj.code > 4'hC |-> dj.fmt == FMT_OFF && dj.p_oe_n && dj.n_oe_n;
        endproperty
        a_reserved: assert property (p_reserved) else $error("reserved code drives");
        property p_off;
            dj.code == 4'h0 |-> dj.fmt == FMT_OFF && dj.p_oe_n && dj.n_oe_n;
        endproperty
        a_off: assert property (p_off) else $error("off code drives");
        property p_true_only;
            dj.code == 4'h1 |-> dj.n_oe_n && dj.fmt == FMT_SE;
        endproperty
        a_true_only: assert property (p_true_only) else $error("complement driven in true-only");
        property p_delay;
            dj.delay <= SKEW_MAX;
        endproperty
        a_delay: assert property (p_delay) else $error("delay above ceiling");
        property p_lvds;
            dj.code inside {[4'h4:4'h7]} |-> dj.low_supply == dj.code[0]
                && dj.fmt == (dj.code[1] ? FMT_LVDS_FAST : FMT_LVDS);
        endproperty
        a_lvds: assert property (p_lvds) else $error("low swing decode wrong");
        property p_hcsl;
            dj.code inside {[4'h8:4'hB]} |-> dj.fmt == FMT_HCSL && dj.term_int == dj.code[0] && dj.imp_42 == dj.code[1];
        endproperty
        a_hcsl: assert property (p_hcsl) else $error("host clock decode wrong");
    end
    property p_spread;
        o_spread_en != $past(o_spread_en) |-> $past(i_bus.wr) || $past(i_bus.wr, 2)
            || $past(i_frequency_select_pin, 2) != $past(i_frequency_select_pin, 3)
            || $past(i_frequency_select_pin, 3) != $past(i_frequency_select_pin, 4);
    endproperty
    a_spread: assert property (p_spread) else $error("spread enable moved unprompted");
endmodule
bind odb_top odb_top_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_frequency_select_pin(i_frequency_select_pin), .o_drv(o_drv), .o_src_clk(o_src_clk), .o_spread_en(o_spread_en));
`default_nettype wire

// >>> sim/output_divider_driver_bank_select_tb_top.sv
`default_nettype none
module output_divider_driver_bank_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import odb_pkg::*;
    logic                 clk;
    logic                 rst_b;
    logic                 pin;
    odb_bus_t             bus;
    logic [31:0]          rdata;
    odb_drv_t [N_OUT-1:0] drv;
    logic [N_SRC-1:0]     src;
    logic [N_FRAC-1:0]    ss;
    int                   mismatches;
    int                   checked;
    logic [31:0]          q;
    logic [31:0]          w;
    odb_drv_t             e;
    int                   n;
    int                   i;

    odb_top DUT (.i_sys_clk(clk), .i_rst_b(rst_b), .i_bus(bus), .o_rdata(rdata),
        .i_frequency_select_pin(pin), .o_drv(drv), .o_src_clk(src), .o_spread_en(ss));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // read: strobe one cycle, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    // write then read back the same place with no gap
    task automatic wrrd(input logic [7:0] a, input logic [31:0] v, output logic [31:0] d);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk);
        rd(a, d);
    endtask
    function automatic logic sig(input int s);
        return (s < N_SRC) ? src[s] : drv[0].p_lvl;
    endfunction
    // cycles between two rising edges of a source or of output 0
    task automatic period(input int s, output int p);
        int c;
        int r;
        logic v;
        logic o;
        c = 0;
        r = 0;
        o = 1'b1;
        repeat (30) @(posedge clk);
        for (int k = 0; k < 300 && r < 2; k++) begin
            @(negedge clk);
            v = sig(s);
            if (r == 1) c++;
            if (v && !o) r++;
            o = v;
        end
        p = (r == 2) ? c : 0;
        @(posedge clk);
    endtask
    // stopped driver expected from an output word
    function automatic odb_drv_t exp_drv(input logic [20:0] x);
        odb_drv_t t;
        logic [3:0] c;
        c = x[11:8];
        t = '0;
        t.code = c;
        t.fmt = (c == 4'h0 || c > 4'hC) ? FMT_OFF : (c < 4'h4) ? FMT_SE : (c < 4'h6) ? FMT_LVDS :
                (c < 4'h8) ? FMT_LVDS_FAST : (c < 4'hC) ? FMT_HCSL : FMT_ECL;
        t.p_oe_n = (t.fmt == FMT_OFF || c == 4'h2) ? 1'b1 : x[16];
        t.n_oe_n = (t.fmt == FMT_OFF || c == 4'h1) ? 1'b1 : x[16];
        t.low_supply = (c == 4'h5 || c == 4'h7);
        t.term_int = (c == 4'h9 || c == 4'hB);
        t.imp_42 = (c == 4'hA || c == 4'hB);
        t.delay = (x[15:12] > 4'h8) ? 4'h8 : x[15:12];
        t.slew = x[19:18];
        t.imp_25 = x[20];
        return t;
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
    initial begin
        rst_b = 1'b0;
        pin = 1'b0;
        bus = '0;
        mismatches = 0;
        checked = 0;
        void'($urandom(22780));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(A_INT_BASE, q);
        chk(q, 32'h00000808);
        rd(A_FRAC_BASE + 8'h04, q);
        chk(q, 32'h00000008);
        wrrd(A_STAT, $urandom, q);
        chk(q, 32'h0);
        wrrd(8'h5C, $urandom, q);
        chk(q, 32'h0);
        $display("register test done");
        for (int k = 0; k < 16; k++) begin
            i = $urandom_range(N_OUT - 1);
            w = $urandom;
            w[5:0] = 6'h0;
            w[11:8] = 4'(k);
            wrrd(A_OUT_BASE + 8'(i * 4), w, q);
            chk(q, w & 32'h001FFF3F);
            e = exp_drv(w[20:0]);
            repeat (4) @(posedge clk);
            @(negedge clk);
            if (e.fmt == FMT_OFF) begin
                chk(32'({drv[i].fmt, drv[i].p_oe_n, drv[i].n_oe_n}), 32'({e.fmt, e.p_oe_n, e.n_oe_n}));
            end else begin
                chk(32'(drv[i]), 32'(e));
            end
            @(posedge clk);
        end
        $display("format test done");
        wrrd(A_INT_BASE, 32'h00000402, q);
        wrrd(A_OUT_BASE, 32'h00020303, q);
        period(0, n);
        chk(n, 2);
        period(7, n);
        chk(n, 6);
        @(negedge clk);
        chk(drv[0].n_lvl, !drv[0].p_lvl);
        @(posedge clk);
        wrrd(A_INT_BASE, 32'h00010402, q);
        period(0, n);
        chk(n, 4);
        period(7, n);
        chk(n, 12);
        rd(A_STAT, q);
        chk(q, 32'h00000001);
        wrrd(A_INT_BASE, 32'h00000402, q);
        wrrd(A_CTRL, 32'h00000100, q);
        pin <= 1'b1;
        repeat (20) @(posedge clk);
        rd(A_STAT, q);
        chk(q, 32'h0000017F);
        period(0, n);
        chk(n, 4);
        pin <= 1'b0;
        repeat (20) @(posedge clk);
        rd(A_STAT, q);
        chk(q, 32'h0);
        $display("bank test done");
        wrrd(A_FRAC_BASE + 8'h04, 32'h00000104, q);
        period(5, n);
        chk(n, 8);
        @(negedge clk);
        chk(ss, 2'b00);
        @(posedge clk);
        wrrd(A_CTRL, 32'h00000001, q);
        period(5, n);
        chk(n, 4);
        @(negedge clk);
        chk(ss, 2'b01);
        @(posedge clk);
        wrrd(A_FRAC_BASE, 32'h00000002, q);
        wrrd(A_FRAC_BASE + 8'h04, 32'h00000004, q);
        @(negedge clk);
        chk(ss, 2'b00);
        @(posedge clk);
        wrrd(A_CTRL, 32'h0, q);
        period(5, n);
        chk(n, 2);
        $display("fractional test done");
        complete_run();
    end
endmodule
`default_nettype wire
